/* core/adc_defines.svh */
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// Register indices; byte address is four times the index.
`define ADC_IDX_CONFIG       8'h00
`define ADC_IDX_MODE         8'h01
`define ADC_IDX_CHANNEL      8'h02
`define ADC_IDX_SCAN         8'h03
`define ADC_IDX_COMMAND      8'h04
`define ADC_IDX_RESERVED     8'h05
`define ADC_IDX_RESULT_FIRST 8'h06
`define ADC_IDX_RESULT_LAST  8'h15
`define ADC_IDX_OFFSET_CAL   8'h16
`define ADC_IDX_GAIN_CAL     8'h17
`define ADC_IDX_CONV_STATUS  8'h18
`define ADC_IDX_INT_STATUS   8'h19
`define ADC_IDX_INT_ENABLE   8'h1A
`define ADC_IDX_INT_CLEAR    8'h1B

// Control register reset values.
`define ADC_CONFIG_RESET     16'h0000
`define ADC_MODE_RESET       16'h0000
`define ADC_CHANNEL_RESET    16'h0000
`define ADC_SCAN_RESET       16'h0000
`define ADC_COMMAND_RESET    16'h0000

// Field positions.
`define ADC_DIV_MSB          3
`define ADC_DIV_LSB          0
`define ADC_FORM_MSB         1
`define ADC_FORM_LSB         0
`define ADC_CONT_BIT         2
`define ADC_CHAN_MSB         3
`define ADC_CHAN_LSB         0
`define ADC_START_BIT        0
`define ADC_INT_DONE_BIT     0
`define ADC_INT_SAT_BIT      1

// Channel numbering.
`define ADC_NUM_SHARED       4'hA
`define ADC_CH_DEDICATED0    4'hA
`define ADC_CH_DEDICATED1    4'hB
`define ADC_CH_GROUND        4'hC
`define ADC_CH_SUPPLY_MUX    4'hD
`define ADC_CH_TEMP_NEG      4'hE
`define ADC_CH_TEMP_POS      4'hF

// Conversion timing and codes.
`define ADC_CONV_CLOCKS      5'h1A
`define ADC_CODE_MIN         12'h000
`define ADC_CODE_MAX         12'hFFF
`define ADC_BIPOLAR_MID      15'h0800

`endif

/* core/adc_pkg.sv */
package adc_pkg;

	typedef enum logic [1:0] {
		CONV_IDLE  = 2'b00,
		CONV_RESET = 2'b01,
		CONV_RUN   = 2'b10
	} conv_state_t;

	typedef enum logic [1:0] {
		FORM_SINGLE   = 2'b00,
		FORM_UNIPOLAR = 2'b01,
		FORM_BIPOLAR  = 2'b10
	} input_form_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic       clk;
		logic       tick;
	} div_state_t;

	typedef struct packed {
		conv_state_t       state;
		logic [4:0]        ticks;
		logic              conv_rst_n;
		logic              done;
		logic [11:0]       result;
		logic [15:0][11:0] ch_result;
		logic [4:0][15:0]  ctrl;
		logic [3:0][15:0]  active;
		logic [1:0][13:0]  raw_sync;
		logic [1:0][11:0]  off_sync;
		logic [1:0][11:0]  gain_sync;
		logic [1:0]        int_status;
		logic [1:0]        int_enable;
		logic              wr_pend;
		logic [7:0]        wr_idx;
		logic [31:0]       hrdata;
	} adc_state_t;

endpackage

/* core/adc_clock_divider.sv */
`timescale 1ns/1ps
`default_nettype none

// Conversion clock: half period is (divider field + 1) port clocks.
module adc_clock_divider
	import adc_pkg::*;
(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Control
	input  wire logic       restart,
	input  wire logic [3:0] clock_divider_field,
	// Divided clock
	output logic            conversion_clock,
	output logic            conversion_tick
);

	div_state_t st;
	div_state_t next_st;

	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		if (restart) begin
			next_st.cnt = 4'h0;
			next_st.clk = 1'b0;
		end else if (st.cnt == clock_divider_field) begin
			next_st.cnt  = 4'h0;
			next_st.clk  = ~st.clk;
			next_st.tick = ~st.clk;
		end else begin
			next_st.cnt = st.cnt + 4'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign conversion_clock = st.clk;
	assign conversion_tick  = st.tick;

endmodule // adc_clock_divider

`default_nettype wire

/* core/adc_conversion_control.sv */
// How it works
// - Twelve user channels: ten shared with GPIO, two dedicated following them.
// - Channel 12 ground, 13 supply monitor mux, 14 and 15 temperature pair.
// - Core result is handed to register logic as a 14-bit word.
// - Single-ended, unipolar and bipolar forms select the code mapping.
// - Single-ended and unipolar: zero gives 000, full scale FFF, saturating.
// - Bipolar: minus half scale 000h, zero 800h, plus half FFFh, saturating.
// - One code step is the span over 4096 in every form.
// - Conversion clock divides the port clock by twice (config divider field + 1).
// - Active-low conversion reset frames each conversion; control values held meanwhile.
// - Done goes high when the result word is complete.
// - A conversion takes at least 26 conversion clocks from reset release.
// - Software writes control registers and reads result and calibration status.
// - Registers 00h-04h read/write control, 05h-18h read-only status, 05h reserved.
// - Divider field sits in bits 3 to 0 of configuration register.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "adc_defines.svh"

module adc_conversion_control
	import adc_pkg::*;
(
	// AHB-Lite slave
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Converter core
	input  wire logic [13:0] core_raw_code,
	input  wire logic [11:0] core_offset_cal,
	input  wire logic [11:0] core_gain_cal,
	output logic             conversion_clock,
	output logic             conversion_reset_n,
	output logic [63:0]      core_control_values,
	output logic [3:0]       core_channel,
	output logic [1:0]       core_input_form,
	// Analog input routing
	output logic [9:0]       shared_pin_analog_inputs_sel,
	output logic [1:0]       dedicated_analog_inputs_sel,
	// Result and interrupt
	output logic             conversion_done,
	output logic [11:0]      conversion_result,
	output logic             irq
);

	adc_state_t  st;
	adc_state_t  next_st;
	logic        conv_tick;
	logic        accept;
	logic [7:0]  acc_idx;
	logic        start_req;
	logic [1:0]  clear_mask;
	logic [1:0]  events;
	logic [3:0]  sel_chan;
	input_form_t form;
	logic [14:0] shifted;
	logic [11:0] mapped;
	logic        saturated;

	adc_clock_divider u_div (
		.hclk                (hclk),
		.hresetn             (hresetn),
		.restart             (!st.conv_rst_n),
		.clock_divider_field (st.active[0][`ADC_DIV_MSB:`ADC_DIV_LSB]),
		.conversion_clock    (conversion_clock),
		.conversion_tick     (conv_tick)
	);

	// Offsets above the register window decode to an index that reads as zero.
	assign accept  = hsel && htrans[1] && hready;
	assign acc_idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'hFF;

	always_comb begin
		sel_chan = st.active[2][`ADC_CHAN_MSB:`ADC_CHAN_LSB];
		form     = (st.active[1][`ADC_FORM_MSB:`ADC_FORM_LSB] == 2'b11) ? FORM_SINGLE :
		           input_form_t'(st.active[1][`ADC_FORM_MSB:`ADC_FORM_LSB]);
		if (sel_chan >= `ADC_CH_TEMP_NEG) begin
			sel_chan = `ADC_CH_TEMP_POS;
			form     = FORM_UNIPOLAR;
		end
		shared_pin_analog_inputs_sel = '0;
		dedicated_analog_inputs_sel  = '0;
		if (sel_chan < `ADC_NUM_SHARED) begin
			shared_pin_analog_inputs_sel[sel_chan] = st.state != CONV_IDLE;
		end else if (sel_chan == `ADC_CH_DEDICATED0 || sel_chan == `ADC_CH_DEDICATED1) begin
			dedicated_analog_inputs_sel[sel_chan[0]] = st.state != CONV_IDLE;
		end
	end

	always_comb begin
		shifted = {st.raw_sync[1][13], st.raw_sync[1]};
		if (form == FORM_BIPOLAR) begin
			shifted = shifted + `ADC_BIPOLAR_MID;
		end
		saturated = 1'b1;
		if (shifted[14]) begin
			mapped = `ADC_CODE_MIN;
		end else if (shifted[13:12] != 2'b00) begin
			mapped = `ADC_CODE_MAX;
		end else begin
			mapped    = shifted[11:0];
			saturated = 1'b0;
		end
	end

	function automatic logic [15:0] read_reg(input adc_state_t s, input logic [7:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		if (idx <= `ADC_IDX_COMMAND) begin
			v = s.ctrl[idx[2:0]];
		end else if (idx >= `ADC_IDX_RESULT_FIRST && idx <= `ADC_IDX_RESULT_LAST) begin
			v = {4'h0, s.ch_result[4'(idx - `ADC_IDX_RESULT_FIRST)]};
		end else if (idx == `ADC_IDX_OFFSET_CAL) begin
			v = {4'h0, s.off_sync[1]};
		end else if (idx == `ADC_IDX_GAIN_CAL) begin
			v = {4'h0, s.gain_sync[1]};
		end else if (idx == `ADC_IDX_CONV_STATUS) begin
			v = {11'h000, s.state != CONV_IDLE, s.active[2][3:0]};
		end else if (idx == `ADC_IDX_INT_STATUS) begin
			v = {14'h0000, s.int_status};
		end else if (idx == `ADC_IDX_INT_ENABLE) begin
			v = {14'h0000, s.int_enable};
		end
		return v;
	endfunction

	always_comb begin
		next_st              = st;
		next_st.done         = 1'b0;
		// The core code and calibration values come from the analog side and pass two flops.
		next_st.raw_sync     = {st.raw_sync[0], core_raw_code};
		next_st.off_sync     = {st.off_sync[0], core_offset_cal};
		next_st.gain_sync    = {st.gain_sync[0], core_gain_cal};
		start_req            = 1'b0;
		clear_mask           = 2'b00;
		events               = 2'b00;

		if (st.wr_pend) begin
			if (st.wr_idx < `ADC_IDX_COMMAND) begin
				next_st.ctrl[st.wr_idx[2:0]] = hwdata[15:0];
			end else if (st.wr_idx == `ADC_IDX_COMMAND) begin
				next_st.ctrl[4]                = hwdata[15:0];
				next_st.ctrl[4][`ADC_START_BIT] = 1'b0;
				start_req                      = hwdata[`ADC_START_BIT];
			end else if (st.wr_idx == `ADC_IDX_INT_ENABLE) begin
				next_st.int_enable = hwdata[1:0];
			end else if (st.wr_idx == `ADC_IDX_INT_CLEAR) begin
				clear_mask = hwdata[1:0];
			end
		end
		next_st.wr_pend = accept && hwrite;
		next_st.wr_idx  = acc_idx;
		// Read data is registered, so it stands through the whole data phase.
		if (accept && !hwrite) begin
			next_st.hrdata = {16'h0000, read_reg(st, acc_idx)};
		end

		unique case (st.state)
			CONV_IDLE: begin
				if (start_req) begin
					next_st.active     = st.ctrl[3:0];
					next_st.conv_rst_n = 1'b0;
					next_st.state      = CONV_RESET;
				end
			end
			CONV_RESET: begin
				next_st.conv_rst_n = 1'b1;
				next_st.ticks      = 5'h00;
				next_st.state      = CONV_RUN;
			end
			CONV_RUN: begin
				if (conv_tick) begin
					next_st.ticks = st.ticks + 5'h01;
					if (st.ticks == `ADC_CONV_CLOCKS - 5'h01) begin
						next_st.done                  = 1'b1;
						next_st.result                = mapped;
						next_st.ch_result[st.active[2][3:0]] = mapped;
						next_st.conv_rst_n            = 1'b0;
						events[`ADC_INT_DONE_BIT]     = 1'b1;
						events[`ADC_INT_SAT_BIT]      = saturated;
						if (st.active[1][`ADC_CONT_BIT]) begin
							next_st.active = st.ctrl[3:0];
							next_st.state  = CONV_RESET;
						end else begin
							next_st.state = CONV_IDLE;
						end
					end
				end
			end
			default: begin
				next_st.conv_rst_n = 1'b0;
				next_st.state      = CONV_IDLE;
			end
		endcase

		// A new event wins over a clear in the same cycle.
		next_st.int_status = (st.int_status & ~clear_mask) | events;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st         <= '0;
			st.ctrl[0] <= `ADC_CONFIG_RESET;
			st.ctrl[1] <= `ADC_MODE_RESET;
			st.ctrl[2] <= `ADC_CHANNEL_RESET;
			st.ctrl[3] <= `ADC_SCAN_RESET;
			st.ctrl[4] <= `ADC_COMMAND_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign hreadyout           = 1'b1;
	assign hresp               = 1'b0;
	assign hrdata              = st.hrdata;
	assign conversion_reset_n  = st.conv_rst_n;
	assign core_control_values = st.active;
	assign core_channel        = sel_chan;
	assign core_input_form     = form;
	assign conversion_done     = st.done;
	assign conversion_result   = st.result;
	assign irq                 = |(st.int_status & st.int_enable);

	// Conversion clocks since the conversion reset was released, counted apart from the state machine.
	logic [4:0] span_ticks;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			span_ticks <= 5'h00;
		end else if (!st.conv_rst_n) begin
			span_ticks <= 5'h00;
		end else if (conv_tick) begin
			span_ticks <= span_ticks + 5'h01;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_done_single_pulse: assert property (conversion_done |=> !conversion_done)
		else $error("done held longer than one cycle");
	a_conv_min_span: assert property (conversion_done |-> span_ticks == `ADC_CONV_CLOCKS)
		else $error("conversion did not span 26 conversion clocks");
	a_reset_frames_start: assert property (st.state == CONV_RESET |-> !conversion_reset_n ##1 conversion_reset_n)
		else $error("conversion reset not framing start");
	a_ctrl_held_run: assert property (st.state == CONV_RUN && $past(st.state) == CONV_RUN |-> $stable(core_control_values))
		else $error("control values changed during conversion");
	a_result_only_on_done: assert property ($changed(conversion_result) |-> conversion_done)
		else $error("result changed outside done");
	a_unipolar_negative: assert property (conversion_done && $past(core_input_form) != FORM_BIPOLAR
		&& $past(st.raw_sync[1][13]) |-> conversion_result == 12'h000)
		else $error("negative input did not saturate to zero");
	a_bipolar_midscale: assert property (conversion_done && $past(core_input_form) == FORM_BIPOLAR
		&& $past(st.raw_sync[1]) == 14'h0000 |-> conversion_result == 12'h800)
		else $error("bipolar zero not mid code");
	a_clock_restart: assert property (!conversion_reset_n |=> !conversion_clock)
		else $error("conversion clock not restarted");
	a_done_irq: assert property (conversion_done && st.int_enable[0] |-> irq)
		else $error("enabled done event did not raise interrupt");
	a_idle_no_route: assert property (st.state == CONV_IDLE |->
		shared_pin_analog_inputs_sel == 10'h000 && dedicated_analog_inputs_sel == 2'h0)
		else $error("analog input routed while idle");
	a_start_latches: assert property (st.state == CONV_RESET && $past(st.state) == CONV_IDLE |->
		core_control_values == $past(st.ctrl[3:0]))
		else $error("control values not latched at start");

	c_one_conversion: cover property (st.state == CONV_RESET ##1 st.state == CONV_RUN);
	c_bipolar_done: cover property (conversion_done && core_input_form == FORM_BIPOLAR);
	c_continuous: cover property (conversion_done && st.state == CONV_RESET);
	c_saturated: cover property (conversion_done && st.int_status[`ADC_INT_SAT_BIT]);
	c_ground_channel: cover property (conversion_done && core_channel == `ADC_CH_GROUND);

endmodule // adc_conversion_control

`default_nettype wire

/* test/adc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Converter core stand-in: shows the commanded difference while a conversion runs.
module adc_core_model #(
	parameter logic [11:0] OFFSET_CAL = 12'h012,
	parameter logic [11:0] GAIN_CAL   = 12'hFE7
) (
	// Clock and core control
	input  wire logic        hclk,
	input  wire logic        conversion_reset_n,
	input  wire logic [3:0]  core_channel,
	input  wire logic [13:0] level,
	// Core outputs
	output logic [13:0]      core_raw_code,
	output logic [11:0]      core_offset_cal,
	output logic [11:0]      core_gain_cal
);
	logic [2:0] hold = 3'h0;

	// The code stays valid a few clocks past the end of a conversion, then goes stale.
	always @(posedge hclk) begin
		if (conversion_reset_n)
			hold <= 3'h7;
		else if (hold != 3'h0)
			hold <= hold - 3'h1;
	end

	always_comb begin
		if (hold == 3'h0)
			core_raw_code = ~level;
		else if (core_channel == 4'hC)
			core_raw_code = 14'h0000;
		else
			core_raw_code = level;
	end

	assign core_offset_cal = OFFSET_CAL;
	assign core_gain_cal   = GAIN_CAL;
endmodule // adc_core_model

`default_nettype wire

/* test/adc_conversion_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_control_tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [13:0] level = 14'h0000, raw;
	logic [11:0] offc, gainc, conversion_result;
	logic        hreadyout, hresp, conversion_clock, conversion_reset_n, conversion_done, irq;
	logic [63:0] core_control_values;
	logic [3:0]  core_channel;
	logic [1:0]  core_input_form, dedicated_sel;
	logic [9:0]  shared_sel;
	wire logic   hready;
	int          mismatches = 0;
	int          n_checks = 0;

	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;

	adc_conversion_control adc_conversion_control_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .core_raw_code(raw), .core_offset_cal(offc),
		.core_gain_cal(gainc), .conversion_clock, .conversion_reset_n, .core_control_values, .core_channel,
		.core_input_form, .shared_pin_analog_inputs_sel(shared_sel), .dedicated_analog_inputs_sel(dedicated_sel),
		.conversion_done, .conversion_result, .irq);

	adc_core_model adc_core_model_inst (.hclk, .conversion_reset_n, .core_channel, .level,
		.core_raw_code(raw), .core_offset_cal(offc), .core_gain_cal(gainc));

	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task stop_hang;
		mismatches++;
		$display("wait limit used up");
		give_verdict;
	endtask

	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			if (n > 50)
				stop_hang;
		end while (hready !== 1'b1);
	endtask

	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask

	task wr(input logic [7:0] i, input logic [15:0] d);
		logic [31:0] x;
		bus(1'b1, {22'h0, i, 2'h0}, {16'h0, d}, x);
	endtask

	task rdchk(input string what, input logic [7:0] i, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, {22'h0, i, 2'h0}, 32'h0, x);
		chk(what, exp, x);
		chk("ready and okay", 64'h2, {hreadyout, hresp});
	endtask

	task t_regs;
		logic [31:0] x;
		for (int i = 0; i < 5; i++)
			rdchk("control reset", i[7:0], 32'h0);
		rdchk("reserved", 8'h05, 32'h0);
		rdchk("offset cal", 8'h16, 32'h012);
		rdchk("gain cal", 8'h17, 32'hFE7);
		for (int i = 0; i < 4; i++)
			wr(i[7:0], 16'h5A5A ^ i[15:0]);
		for (int i = 0; i < 4; i++)
			rdchk("control readback", i[7:0], 32'h5A5A ^ i);
		wr(8'h05, 16'hFFFF);
		wr(8'h16, 16'h0F0F);
		rdchk("reserved write", 8'h05, 32'h0);
		rdchk("status write", 8'h16, 32'h012);
		bus(1'b0, 32'h0000_0400, 32'h0, x);
		chk("unmapped", 32'h0, x);
		$display("register test done");
	endtask

	task conv(input logic [3:0] div, input logic [1:0] form, input logic [3:0] ch, input logic [13:0] lv);
		logic [1:0]         ef;
		logic signed [15:0] v;
		logic [11:0]        e;
		logic               pc;
		int                 n, rises, run, hp;
		ef = ch >= 4'hE ? 2'h1 : (form == 2'h3 ? 2'h0 : form);
		v = ch == 4'hC ? 16'sh0 : {{2{lv[13]}}, lv};
		if (ef == 2'h2)
			v = v + 16'sh0800;
		e = v < 0 ? 12'h000 : (v > 16'sh0FFF ? 12'hFFF : v[11:0]);
		level <= lv;
		wr(8'h00, {12'h0, div});
		wr(8'h01, {14'h0, form});
		wr(8'h02, {12'h0, ch});
		wr(8'h03, 16'hC3A5);
		wr(8'h04, 16'h0001);
		{n, rises, run, hp} = '0;
		pc = conversion_clock;
		do begin
			@(posedge hclk);
			n++;
			if (n > 4000)
				stop_hang;
			if (conversion_reset_n !== 1'b1) begin
				if (rises == 0)
					chk("clock parked", 64'h0, conversion_clock);
			end else if (conversion_clock !== pc) begin
				if (pc === 1'b0)
					rises++;
				if (hp > 0)
					chk("half period", div + 1, run);
				if (rises == 1 && pc === 1'b0) begin
					chk("channel", ch >= 4'hE ? 4'hF : ch, core_channel);
					chk("form", ef, core_input_form);
					chk("controls", {16'hC3A5, 12'h0, ch, 14'h0, form, 12'h0, div}, core_control_values);
					chk("shared sel", ch < 4'hA ? 10'h001 << ch : 10'h000, shared_sel);
					chk("dedicated sel", ch == 4'hA ? 2'h1 : (ch == 4'hB ? 2'h2 : 2'h0), dedicated_sel);
				end
				hp++;
				run = 0;
			end
			run++;
			pc = conversion_clock;
		end while (conversion_done !== 1'b1);
		chk("conversion length", 64'h1, rises >= 26 && rises <= 27);
		chk("result", e, conversion_result);
		@(posedge hclk);
		chk("done pulse", 64'h0, conversion_done);
		chk("result held", e, conversion_result);
		rdchk("stored result", 8'h06 + {4'h0, ch}, {20'h0, e});
		$display("conversion on channel %0d done", ch);
	endtask

	task t_conversions;
		conv(4'h0, 2'h0, 4'h3, 14'h0064);
		conv(4'h1, 2'h0, 4'h9, 14'h3FFB);
		conv(4'h0, 2'h0, 4'hB, 14'h1388);
		conv(4'h3, 2'h1, 4'hA, 14'h04D2);
		conv(4'h0, 2'h2, 4'h0, 14'h0000);
		conv(4'h1, 2'h2, 4'h5, 14'h3800);
		conv(4'h0, 2'h2, 4'h7, 14'h07FF);
		conv(4'h0, 2'h2, 4'h6, 14'h3448);
		conv(4'hF, 2'h2, 4'hC, 14'h0309);
		conv(4'h0, 2'h2, 4'hE, 14'h0BB8);
		conv(4'h0, 2'h3, 4'hD, 14'h0FFF);
	endtask

	task t_interrupts;
		wr(8'h1B, 16'h0003);
		wr(8'h1A, 16'h0001);
		rdchk("status cleared", 8'h19, 32'h0);
		chk("irq idle", 64'h0, irq);
		conv(4'h0, 2'h0, 4'h2, 14'h0010);
		rdchk("done status", 8'h19, 32'h1);
		chk("irq raised", 64'h1, irq);
		wr(8'h1A, 16'h0000);
		rdchk("enable", 8'h1A, 32'h0);
		chk("irq masked", 64'h0, irq);
		wr(8'h1B, 16'h0001);
		rdchk("status after clear", 8'h19, 32'h0);
		wr(8'h1A, 16'h0002);
		conv(4'h0, 2'h0, 4'h1, 14'h1FFF);
		rdchk("saturated status", 8'h19, 32'h3);
		chk("irq saturated", 64'h1, irq);
		wr(8'h1B, 16'h0003);
		rdchk("clear reads zero", 8'h1B, 32'h0);
		chk("irq cleared", 64'h0, irq);
		$display("interrupt test done");
	endtask

	task t_continuous;
		int n, dones;
		level <= 14'h0123;
		wr(8'h00, 16'h0000);
		wr(8'h02, 16'h0004);
		wr(8'h01, 16'h0004);
		wr(8'h04, 16'h0001);
		wr(8'h01, 16'h0000);
		{n, dones} = '0;
		while (n < 400) begin
			@(posedge hclk);
			n++;
			if (conversion_done === 1'b1) begin
				dones++;
				chk("continuous result", 64'h123, conversion_result);
			end
		end
		chk("continuous count", 64'h2, dones);
		rdchk("idle after stop", 8'h18, 32'h4);
		$display("continuous test done");
	endtask

	initial begin
		repeat (16) @(posedge hclk);
		chk("done in reset", 64'h0, conversion_done);
		chk("ready in reset", 64'h1, hreadyout);
		hresetn <= 1'b1;
		t_regs;
		t_conversions;
		t_interrupts;
		t_continuous;
		give_verdict;
	end
endmodule // adc_conversion_control_tb

`default_nettype wire
